// >>> rtl/dcc_channel.sv
// dcc_channel: dual channel capture/compare with AXI4-Lite register access
`timescale 1ns/10ps
module dcc_channel
	import dcc_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// time base buses
	input wire logic [COUNT_WIDTH-1:0] timeBaseA,
	input wire logic [COUNT_WIDTH-1:0] timeBaseB,
	// channel pin
	input wire logic pinIn,
	output dcc_pin_type pin,
	// interrupt request level, zero when idle
	output logic [2:0] irqRequest,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************
	// state
	// ****************************************
	logic flag;
	logic [2:0] irqPriority;
	logic arbBit;
	logic openDrain;
	logic timebaseSelect;
	logic edgePolarity;
	logic [3:0] opSelect;
	logic [15:0] dataA;
	logic [15:0] firstStageHold;
	logic [15:0] secondStageHold;
	logic armA;
	logic armB;
	logic outFlop;
	logic firstSeen;
	logic pinLast;
	logic flagReadOne;
	logic [3:0] awAddr;
	logic awHeld;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic wHeld;
	dcc_kind_type kind;
	dcc_kind_type lastKind;

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		if (opSelect[3])
			kind = DCC_KIND_MODULATED;
		else if (opSelect[3:1] == DCC_OP_COMPARE_HI)
			kind = DCC_KIND_COMPARE;
		else if (opSelect == DCC_OP_CHANNEL_OFF)
			kind = DCC_KIND_OFF;
		else
			kind = DCC_KIND_CAPTURE;
	end

	logic [15:0] count;
	assign count = 16'(timebaseSelect ? timeBaseB : timeBaseA);

	// resolution mask: 000 keeps all 16 bits, others mask high bits
	logic [15:0] resMask;
	always_comb begin
		unique case (opSelect[2:0])
			3'h0: resMask = 16'hffff;
			3'h1: resMask = 16'h7fff;
			3'h2: resMask = 16'h3fff;
			3'h3: resMask = 16'h1fff;
			3'h4: resMask = 16'h0fff;
			3'h5: resMask = 16'h07ff;
			3'h6: resMask = 16'h01ff;
			default: resMask = 16'h007f;
		endcase
	end

	logic isMod;
	logic isCmp;
	assign isMod = (kind == DCC_KIND_MODULATED);
	assign isCmp = (kind == DCC_KIND_COMPARE);

	// modulated compares ignore masked bus bits so period is 2^unmasked
	logic matchA;
	logic matchB;
	logic fullHigh;
	assign fullHigh = isMod && (opSelect[2:0] != 3'h0) && secondStageHold[15];
	assign matchA = isMod ? ((count & resMask) == (dataA & resMask))
		: (isCmp && armA && count == dataA);
	assign matchB = isMod ? (!fullHigh && (count & resMask) == (secondStageHold & resMask))
		: (isCmp && armB && count == secondStageHold);

	// capture edge detection
	logic pinRise;
	logic pinFall;
	logic capEdge;
	assign pinRise = pinIn && !pinLast;
	assign pinFall = !pinIn && pinLast;
	assign capEdge = edgePolarity ? pinFall : pinRise;
	logic capPeriod;
	assign capPeriod = (kind == DCC_KIND_CAPTURE) && opSelect != DCC_OP_WIDTH_CAPTURE && capEdge;

	// flag events
	logic flagEvent;
	always_comb begin
		flagEvent = 1'b0;
		if (capPeriod)
			flagEvent = firstSeen || opSelect == DCC_OP_SINGLE_EDGE_CAPTURE;
		else if (isCmp)
			flagEvent = matchB || (opSelect[0] && matchA);
		else if (isMod)
			flagEvent = matchA;
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic doWrite;
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 4'h0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DCC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr[1:0] != 2'h0) ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic wrCtrl;
	logic wrA;
	logic wrB;
	logic lo;
	logic hi;
	assign lo = wStrb[0];
	assign hi = wStrb[1];
	assign wrCtrl = doWrite && awAddr == DCC_OFS_CTRL;
	assign wrA = doWrite && awAddr == DCC_OFS_DATA_A && (lo || hi);
	assign wrB = doWrite && awAddr == DCC_OFS_DATA_B && (lo || hi);
	logic [15:0] newA;
	logic [15:0] newB;
	assign newA = {hi ? wData[15:8] : dataA[15:8], lo ? wData[7:0] : dataA[7:0]};
	assign newB = isMod || kind != DCC_KIND_COMPARE
		? {hi ? wData[15:8] : firstStageHold[15:8], lo ? wData[7:0] : firstStageHold[7:0]}
		: {hi ? wData[15:8] : secondStageHold[15:8], lo ? wData[7:0] : secondStageHold[7:0]};

	logic pinLevel;
	assign pinLevel = outFlop ^ edgePolarity;
	logic [15:0] ctrlRead;
	assign ctrlRead = {flag, irqPriority, arbBit, 1'b0, openDrain, timebaseSelect,
		(isCmp || isMod) ? pinLevel : pinIn, 2'b00, edgePolarity, opSelect};
	logic rdCtrl;
	assign rdCtrl = s_axi_arvalid && s_axi_arready && s_axi_araddr == DCC_OFS_CTRL;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= DCC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= (s_axi_araddr[1:0] != 2'h0) ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
			unique case (s_axi_araddr)
				DCC_OFS_CTRL: s_axi_rdata <= {16'h0000, ctrlRead};
				DCC_OFS_DATA_A: s_axi_rdata <= {16'h0000, dataA};
				DCC_OFS_DATA_B: s_axi_rdata <= {16'h0000, isMod ? firstStageHold : secondStageHold};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{irqPriority, arbBit, openDrain, timebaseSelect, edgePolarity, opSelect} <= 11'h000;
		end else if (wrCtrl) begin
			if (hi) begin
				irqPriority <= wData[DCC_BIT_IRQ_LO+:3];
				arbBit <= wData[DCC_BIT_ARB];
				openDrain <= wData[DCC_BIT_OPEN_DRAIN];
				timebaseSelect <= wData[DCC_BIT_TBSEL];
			end
			if (lo) begin
				edgePolarity <= wData[DCC_BIT_EDGE_POL];
				opSelect <= wData[3:0];
			end
		end
	end

	// flag: set wins over the clear; a set after the read-one cancels the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag <= 1'b0;
			flagReadOne <= 1'b0;
		end else begin
			if (kind == DCC_KIND_OFF)
				flag <= 1'b0;
			else if (flagEvent)
				flag <= 1'b1;
			else if (wrCtrl && hi && !wData[DCC_BIT_FLAG] && flagReadOne)
				flag <= 1'b0;
			if (flagEvent)
				flagReadOne <= 1'b0;
			else if (rdCtrl)
				flagReadOne <= flag;
			else if (wrCtrl && hi)
				flagReadOne <= 1'b0;
		end
	end

	assign irqRequest = flag ? irqPriority : 3'h0;

	// ****************************************
	// data registers and comparator arming
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lastKind <= DCC_KIND_OFF;
			pinLast <= 1'b0;
		end else begin
			lastKind <= kind;
			pinLast <= pinIn;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dataA <= DCC_DATA_RESET;
			firstStageHold <= DCC_DATA_RESET;
			secondStageHold <= DCC_DATA_RESET;
			firstSeen <= 1'b0;
		end else begin
			if (kind != DCC_KIND_CAPTURE)
				firstSeen <= 1'b0;
			if (capPeriod) begin
				dataA <= count;
				secondStageHold <= firstStageHold;
				firstStageHold <= count;
				firstSeen <= 1'b1;
			end else begin
				if (wrA)
					dataA <= newA;
				if (wrB && isCmp)
					secondStageHold <= newB;
				else if (wrB) begin
					firstStageHold <= newB;
					if (kind == DCC_KIND_OFF)
						secondStageHold <= newB;
				end
				// copy only while the output is in its trailing phase: synchronous to the period
				// at full duty there is no trailing phase, so the copy waits for the leading match instead
				if (isMod && !wrB && ((!outFlop && !matchA) || (fullHigh && matchA)))
					secondStageHold <= firstStageHold;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armA <= 1'b0;
			armB <= 1'b0;
		end else if (isCmp && lastKind != DCC_KIND_COMPARE) begin
			armA <= 1'b0;
			armB <= 1'b0;
		end else begin
			// comparator B is not held off while A is armed
			if (wrA)
				armA <= 1'b1;
			else if (matchA && isCmp)
				armA <= 1'b0;
			if (wrB)
				armB <= 1'b1;
			else if (matchB && isCmp)
				armB <= 1'b0;
		end
	end

	// ****************************************
	// output flip-flop
	// ****************************************
	logic forceLead;
	logic forceTrail;
	assign forceLead = wrCtrl && lo && wData[DCC_BIT_FORCE_LEAD];
	assign forceTrail = wrCtrl && lo && wData[DCC_BIT_FORCE_TRAIL];

	always_ff @(posedge clk) begin
		if (!rst_n)
			outFlop <= 1'b0;
		else if (isCmp || isMod) begin
			if ((matchA && matchB) || (forceLead && forceTrail))
				outFlop <= 1'b0;
			else if (matchA || forceLead || (fullHigh && matchA))
				outFlop <= 1'b1;
			else if (matchB || forceTrail)
				outFlop <= 1'b0;
		end
	end

	// open drain only pulls low; totem pole drives whenever in compare or modulated mode
	always_comb begin
		pin.out = pinLevel;
		pin.oe = (isCmp || isMod) && (!openDrain || !pinLevel);
	end

	// ****************************************
	// checks
	// ****************************************
	AST_FLAG_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		kind == DCC_KIND_OFF |=> !flag) else $error("flag not cleared in channel off");
	AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
		irqRequest == (flag ? irqPriority : 3'h0)) else $error("irq level wrong");
	AST_LEAD: assert property (@(posedge clk) disable iff (!rst_n)
		(isCmp && matchA && !matchB && !forceTrail) |=> outFlop) else $error("leading match missed");
	AST_TRAIL: assert property (@(posedge clk) disable iff (!rst_n)
		(isCmp && matchB && !forceLead) |=> !outFlop) else $error("trailing match missed");
	AST_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
		(isMod && matchA && matchB) |=> !outFlop) else $error("tie not resolved low");
	AST_DISARM: assert property (@(posedge clk) disable iff (!rst_n)
		(isCmp && matchA && !wrA && $past(isCmp)) |=> !armA) else $error("comparator stays armed");
	AST_FLAG_B: assert property (@(posedge clk) disable iff (!rst_n)
		(isCmp && !opSelect[0] && matchA && !matchB) |=> $stable(flag) || !flag) else $error("flag on lead");
	AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
		capPeriod |=> dataA == $past(count) && firstStageHold == $past(count)) else $error("capture lost");
	AST_POL: assert property (@(posedge clk) disable iff (!rst_n)
		pin.out == (outFlop ^ edgePolarity)) else $error("pin polarity wrong");
	AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
		(flagEvent && kind != DCC_KIND_OFF) |=> flag) else $error("flag event lost");

	COV_PULSE: cover property (@(posedge clk) disable iff (!rst_n) isCmp && matchA ##[1:200] matchB);
	COV_MOD: cover property (@(posedge clk) disable iff (!rst_n) isMod && matchA);
	COV_CAP: cover property (@(posedge clk) disable iff (!rst_n) capPeriod && firstSeen);
	COV_FULL: cover property (@(posedge clk) disable iff (!rst_n) fullHigh && outFlop);
endmodule : dcc_channel

// >>> rtl/dcc_pkg.sv
// dcc_pkg: constants and types for the dual channel capture/compare block
package dcc_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [3:0] DCC_OFS_CTRL = 4'h0;
	localparam logic [3:0] DCC_OFS_DATA_A = 4'h4;
	localparam logic [3:0] DCC_OFS_DATA_B = 4'h8;
	localparam logic [3:0] DCC_OFS_RSVD = 4'hc;
	// ****************************************
	// control register field positions
	// ****************************************
	localparam int DCC_BIT_FLAG = 15;
	localparam int DCC_BIT_IRQ_LO = 12;
	localparam int DCC_BIT_ARB = 11;
	localparam int DCC_BIT_OPEN_DRAIN = 9;
	localparam int DCC_BIT_TBSEL = 8;
	localparam int DCC_BIT_PIN = 7;
	localparam int DCC_BIT_FORCE_LEAD = 6;
	localparam int DCC_BIT_FORCE_TRAIL = 5;
	localparam int DCC_BIT_EDGE_POL = 4;
	localparam logic [15:0] DCC_CTRL_RESET = 16'h0000;
	localparam logic [15:0] DCC_DATA_RESET = 16'h0000;
	localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
	// ****************************************
	// operation select codes
	// ****************************************
	localparam logic [3:0] DCC_OP_CHANNEL_OFF = 4'h0;
	localparam logic [3:0] DCC_OP_WIDTH_CAPTURE = 4'h1;
	localparam logic [3:0] DCC_OP_PERIOD_CAPTURE = 4'h2;
	localparam logic [3:0] DCC_OP_SINGLE_EDGE_CAPTURE = 4'h3;
	localparam logic [2:0] DCC_OP_COMPARE_HI = 3'h2;

	typedef enum logic [3:0] {
		DCC_KIND_OFF = 4'b0001,
		DCC_KIND_CAPTURE = 4'b0010,
		DCC_KIND_COMPARE = 4'b0100,
		DCC_KIND_MODULATED = 4'b1000
	} dcc_kind_type;

	// pin side bundle
	typedef struct packed {
		logic out;
		logic oe;
	} dcc_pin_type;
endpackage : dcc_pkg

// >>> bench/dcc_pin_model.sv
// pin partner: external driver on the channel pin with a pull-up
`timescale 1ns/10ps
module dcc_pin_model
	import dcc_pkg::*;
(
	// block side
	input wire dcc_pin_type pin,
	// bench side
	input wire logic extLevel,
	input wire logic extDrive,
	output logic pinIn
);
	// **********************
	// wire resolution
	// **********************
	// pull-up so a released open drain line reads high, never a stale level
	always_comb begin
		if (pin.oe)
			pinIn = pin.out;
		else if (extDrive)
			pinIn = extLevel;
		else
			pinIn = 1'b1;
	end
endmodule : dcc_pin_model

// >>> bench/dcc_channel_tb.sv
// testbench for the dual channel capture/compare block
`timescale 1ns/10ps
module dcc_channel_tb;
	import dcc_pkg::*;
	localparam logic [15:0] FLAGM = 16'h0001 << DCC_BIT_FLAG;
	localparam logic [15:0] PINM = 16'h0001 << DCC_BIT_PIN;
	localparam logic [15:0] LEADM = 16'h0001 << DCC_BIT_FORCE_LEAD;
	localparam logic [15:0] TRAILM = 16'h0001 << DCC_BIT_FORCE_TRAIL;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] tbA = 16'h0000;
	logic [15:0] tbB = 16'h0000;
	logic runTb = 1'b0;
	logic extLevel = 1'b0;
	logic extDrive = 1'b1;
	logic pinIn;
	dcc_pin_type pin;
	logic [2:0] irqRequest;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [1:0] rs;
	logic [15:0] c;
	int n_mismatch = 0;
	int checks = 0;
	int k;

	always #12.5 clk = ~clk;
	// free running time base, only while modulated output is under test
	always @(posedge clk) if (runTb) tbA <= tbA + 16'h0001;

	dcc_channel dut_u (.clk(clk), .rst_n(rst_n), .timeBaseA(tbA), .timeBaseB(tbB), .pinIn(pinIn), .pin(pin),
		.irqRequest(irqRequest), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dcc_pin_model pin_u (.pin(pin), .extLevel(extLevel), .extDrive(extDrive), .pinIn(pinIn));

	// **********************
	// shared tasks
	// **********************
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chkB(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkB

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic hang();
		n_mismatch++;
		$display("FAIL t=%0t got %h exp %h", $time, 1'b0, 1'b1);
		finish_test();
	endtask : hang

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		int n;
		logic awTaken;
		logic wTaken;
		logic bSeen;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		// ready is combinational: sample it settled before the edge that takes the item
		do begin
			@(negedge clk);
			awTaken = awvalid && awready === 1'b1;
			wTaken = wvalid && wready === 1'b1;
			bSeen = bvalid === 1'b1;
			@(posedge clk);
			if (awTaken) awvalid <= 1'b0;
			if (wTaken) wvalid <= 1'b0;
			n++;
		end while (!bSeen && n < 50);
		if (n >= 50) hang();
		bready <= 1'b0;
	endtask : wr

	task automatic rdReg(input logic [3:0] a);
		int n;
		logic arTaken;
		logic rSeen;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			arTaken = arvalid && arready === 1'b1;
			rSeen = rvalid === 1'b1;
			if (rSeen) begin
				rd = rdata;
				rs = rresp;
			end
			@(posedge clk);
			if (arTaken) arvalid <= 1'b0;
			n++;
		end while (!rSeen && n < 50);
		if (n >= 50) hang();
		rready <= 1'b0;
	endtask : rdReg

	task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
		rdReg(a);
		chk(rd, {16'h0, exp});
	endtask : rdChk

	task automatic pinTo(input logic v);
		@(posedge clk);
		extLevel <= v;
		cyc(4);
	endtask : pinTo

	task automatic countHigh(input int p);
		k = 0;
		repeat (p) begin
			@(negedge clk);
			if (pin.out === 1'b1) k++;
		end
	endtask : countHigh

	function automatic logic [15:0] mkCtrl(input logic [2:0] irq, input logic od, input logic tb, input logic pol,
		input logic [3:0] op);
		mkCtrl = 16'h0000;
		mkCtrl[DCC_BIT_IRQ_LO+:3] = irq;
		mkCtrl[DCC_BIT_OPEN_DRAIN] = od;
		mkCtrl[DCC_BIT_TBSEL] = tb;
		mkCtrl[DCC_BIT_EDGE_POL] = pol;
		mkCtrl[3:0] = op;
	endfunction : mkCtrl

	// **********************
	// scenarios
	// **********************
	task automatic tReset();
		logic [3:0] ofs [4] = '{DCC_OFS_CTRL, DCC_OFS_DATA_A, DCC_OFS_DATA_B, DCC_OFS_RSVD};
		chk({29'h0, irqRequest}, 32'h0);
		chkB(pin.oe, 1'b0);
		wr(DCC_OFS_RSVD, 16'hffff);
		foreach (ofs[i]) begin
			rdChk(ofs[i], 16'h0000);
			chk({30'h0, rs}, {30'h0, DCC_RESP_OKAY});
		end
		rdReg(4'h2);
		chk({30'h0, rs}, {30'h0, DCC_RESP_SLVERR});
		$display("test reset done");
	endtask : tReset

	task automatic tCapture();
		c = mkCtrl(3'h5, 1'b0, 1'b1, 1'b0, DCC_OP_SINGLE_EDGE_CAPTURE);
		wr(DCC_OFS_CTRL, c);
		tbA <= 16'h1111;
		tbB <= 16'h2222;
		pinTo(1'b1);
		rdChk(DCC_OFS_DATA_A, 16'h2222);
		rdChk(DCC_OFS_CTRL, c | FLAGM | PINM);
		chk({29'h0, irqRequest}, 32'h5);
		tbB <= 16'h3333;
		pinTo(1'b0);
		pinTo(1'b1);
		rdChk(DCC_OFS_DATA_A, 16'h3333);
		rdChk(DCC_OFS_DATA_B, 16'h2222);
		rdReg(DCC_OFS_CTRL);
		wr(DCC_OFS_CTRL, c);
		rdChk(DCC_OFS_CTRL, c | PINM);
		chk({29'h0, irqRequest}, 32'h0);
		pinTo(1'b0);
		pinTo(1'b1);
		rdReg(DCC_OFS_CTRL);
		pinTo(1'b0);
		pinTo(1'b1);
		wr(DCC_OFS_CTRL, c);
		rdChk(DCC_OFS_CTRL, c | FLAGM | PINM);
		wr(DCC_OFS_CTRL, 16'h0000);
		rdChk(DCC_OFS_CTRL, PINM);
		$display("test capture done");
	endtask : tCapture

	task automatic tPeriod();
		c = mkCtrl(3'h3, 1'b0, 1'b0, 1'b1, DCC_OP_PERIOD_CAPTURE);
		wr(DCC_OFS_CTRL, c);
		tbA <= 16'h0100;
		pinTo(1'b0);
		rdChk(DCC_OFS_CTRL, c);
		rdChk(DCC_OFS_DATA_A, 16'h0100);
		tbA <= 16'h0180;
		pinTo(1'b1);
		pinTo(1'b0);
		rdChk(DCC_OFS_DATA_A, 16'h0180);
		rdChk(DCC_OFS_DATA_B, 16'h0100);
		rdChk(DCC_OFS_CTRL, c | FLAGM);
		chk({29'h0, irqRequest}, 32'h3);
		wr(DCC_OFS_CTRL, 16'h0000);
		$display("test period done");
	endtask : tPeriod

	task automatic tCompare();
		c = mkCtrl(3'h2, 1'b0, 1'b0, 1'b0, 4'h4);
		extDrive <= 1'b0;
		tbA <= 16'h0000;
		wr(DCC_OFS_CTRL, c);
		chkB(pin.out, 1'b0);
		chkB(pin.oe, 1'b1);
		wr(DCC_OFS_DATA_A, 16'h0010);
		wr(DCC_OFS_DATA_B, 16'h0020);
		tbA <= 16'h0010;
		cyc(3);
		chkB(pin.out, 1'b1);
		rdReg(DCC_OFS_CTRL);
		chkB(rd[DCC_BIT_FLAG], 1'b0);
		tbA <= 16'h0020;
		cyc(3);
		chkB(pin.out, 1'b0);
		rdReg(DCC_OFS_CTRL);
		chkB(rd[DCC_BIT_FLAG], 1'b1);
		tbA <= 16'h0010;
		cyc(3);
		chkB(pin.out, 1'b0);
		wr(DCC_OFS_DATA_A, 16'h0010);
		cyc(3);
		chkB(pin.out, 1'b1);
		wr(DCC_OFS_DATA_A, 16'h0030);
		wr(DCC_OFS_DATA_B, 16'h0030);
		tbA <= 16'h0030;
		cyc(3);
		chkB(pin.out, 1'b0);
		// mode change goes through channel off so the comparators start disarmed
		wr(DCC_OFS_CTRL, 16'h0000);
		c = mkCtrl(3'h0, 1'b0, 1'b0, 1'b0, 4'h5);
		tbA <= 16'h0000;
		wr(DCC_OFS_CTRL, c);
		wr(DCC_OFS_DATA_A, 16'h0040);
		tbA <= 16'h0040;
		cyc(3);
		chkB(pin.out, 1'b1);
		rdReg(DCC_OFS_CTRL);
		chkB(rd[DCC_BIT_FLAG], 1'b1);
		chk({29'h0, irqRequest}, 32'h0);
		tbA <= 16'h0000;
		cyc(3);
		chkB(pin.out, 1'b1);
		wr(DCC_OFS_CTRL, c | FLAGM | TRAILM);
		chkB(pin.out, 1'b0);
		rdReg(DCC_OFS_CTRL);
		chkB(rd[DCC_BIT_FLAG], 1'b1);
		c = mkCtrl(3'h0, 1'b1, 1'b0, 1'b1, 4'h5) | FLAGM;
		wr(DCC_OFS_CTRL, c);
		chkB(pin.out, 1'b1);
		chkB(pin.oe, 1'b0);
		chkB(pinIn, 1'b1);
		wr(DCC_OFS_CTRL, c | LEADM);
		chkB(pin.out, 1'b0);
		chkB(pin.oe, 1'b1);
		wr(DCC_OFS_CTRL, 16'h0000);
		$display("test compare done");
	endtask : tCompare

	task automatic tModulated();
		int bits [4] = '{12, 11, 9, 7};
		int p;
		runTb <= 1'b1;
		wr(DCC_OFS_CTRL, mkCtrl(3'h1, 1'b0, 1'b0, 1'b0, 4'hf));
		wr(DCC_OFS_DATA_A, 16'h0010);
		wr(DCC_OFS_DATA_B, 16'h0040);
		// high time is B minus A counts, whatever the phase of the window
		for (int m = 4; m < 8; m++) begin
			p = 1 << bits[m - 4];
			wr(DCC_OFS_CTRL, mkCtrl(3'h1, 1'b0, 1'b0, 1'b0, 4'h8 | m[3:0]));
			cyc(p + 20);
			countHigh(p);
			chk(k, 32'h30);
		end
		rdReg(DCC_OFS_CTRL);
		chkB(rd[DCC_BIT_FLAG], 1'b1);
		chk({29'h0, irqRequest}, 32'h1);
		wr(DCC_OFS_DATA_B, 16'h8040);
		cyc(300);
		countHigh(128);
		chk(k, 32'd128);
		wr(DCC_OFS_DATA_B, 16'h0040);
		cyc(300);
		countHigh(128);
		chk(k, 32'h30);
		runTb <= 1'b0;
		$display("test modulated done");
	endtask : tModulated

	initial begin
		cyc(20);
		rst_n <= 1'b1;
		tReset();
		tCapture();
		tPeriod();
		tCompare();
		tModulated();
		finish_test();
	end
endmodule : dcc_channel_tb
